// file: common/csr_decode_pkg.sv
/*
 Constants, region enumeration and carrier structs for the control and status
 address decoder. Assumes a word-addressed host port on the status clock.
*/
package csr_decode_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   // single-word pcs registers
   localparam logic [15:0] PCS_HW_ERROR_OFS = 16'h0017;
   localparam logic [15:0] BER_MONITOR_OFS = 16'h0018;
   localparam logic [15:0] TEST_MODE_OFS = 16'h0019;
   localparam logic [15:0] TEST_PATTERN_OFS = 16'h001A;
   localparam logic [15:0] LINK_FAULT_OFS = 16'h001B;
   localparam logic [15:0] PHY_RESET_OFS = 16'h001D;
   // ranges as first and last word
   localparam logic [15:0] XCVR_CSR_LO = 16'h0000;
   localparam logic [15:0] XCVR_CSR_HI = 16'h0009;
   localparam logic [15:0] LOCK_LO = 16'h0010;
   localparam logic [15:0] LOCK_HI = 16'h0014;
   localparam logic [15:0] BIT_ERR_LO = 16'h0015;
   localparam logic [15:0] BIT_ERR_HI = 16'h0016;
   localparam logic [15:0] VLANE_LO = 16'h0020;
   localparam logic [15:0] VLANE_HI = 16'h0023;
   localparam logic [15:0] PATTERN_LO = 16'h0030;
   localparam logic [15:0] PATTERN_HI = 16'h0032;
   localparam logic [15:0] WINDOW_LO = 16'h0040;
   localparam logic [15:0] WINDOW_HI = 16'h007F;
   localparam logic [15:0] KR4_LO = 16'h0080;
   localparam logic [15:0] KR4_FEC_LO = 16'h00B0;
   localparam logic [15:0] KR4_FEC_HI = 16'h00BD;
   localparam logic [15:0] KR4_AN_LO = 16'h00C0;
   localparam logic [15:0] KR4_AN_HI = 16'h00CC;
   localparam logic [15:0] KR4_LT_LO = 16'h00D0;
   localparam logic [15:0] KR4_LT_HI = 16'h00EB;
   localparam logic [15:0] MAC_LO = 16'h0100;
   // fixed answer for reserved and absent locations
   localparam logic [31:0] RESERVED_DATA = 32'h0000_0000;
   // writable masks and reset values of the local registers
   localparam logic [31:0] TEST_MODE_WMASK = 32'h0000_000F;
   localparam logic [31:0] LINK_FAULT_WMASK = 32'h0000_0007;
   localparam logic [31:0] PHY_RESET_WMASK = 32'h0000_0007;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // decoded target area
   typedef enum logic [3:0] {
      RGN_RESERVED = 4'b0000,
      RGN_XCVR_CSR = 4'b0001,
      RGN_LOCK = 4'b0010,
      RGN_BIT_ERR = 4'b0011,
      RGN_LOCAL = 4'b0100,
      RGN_VLANE = 4'b0101,
      RGN_PATTERN = 4'b0110,
      RGN_WINDOW = 4'b0111,
      RGN_KR4_FEC = 4'b1000,
      RGN_KR4_AN = 4'b1001,
      RGN_KR4_LT = 4'b1010,
      RGN_MAC = 4'b1011
   } region_e;

   // host request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic read;
      logic write;
      logic [DATA_W-1:0] wdata;
   } host_req_s;

   // host answer
   typedef struct packed {
      logic [DATA_W-1:0] rdata;
      logic rvalid;
   } host_rsp_s;

   // access routed to an external area
   typedef struct packed {
      region_e region;
      logic [ADDR_W-1:0] addr;
      logic read;
      logic write;
      logic [DATA_W-1:0] wdata;
   } area_req_s;
endpackage : csr_decode_pkg

// file: hdl/csr_region_decode.sv
/*
 Combinational word-address to region decoder.
 Assumes build options are static strap parameters.
*/
`timescale 1ns/100ps
module csr_region_decode import csr_decode_pkg::*; #(
   parameter bit OLDER_FAMILY = 1'b0,
   parameter bit FOUR_LANE = 1'b0,
   parameter bit HAS_KR4 = 1'b1
) (
   // word address in, region out
   input wire logic [ADDR_W-1:0] addr,
   output region_e region
);
   // priority range compare over the word address
   always_comb begin
      region = RGN_RESERVED;
      if (addr >= MAC_LO) begin
         region = RGN_MAC;
      end else if (addr >= KR4_LO) begin
         if (HAS_KR4) begin
            if (addr >= KR4_FEC_LO && addr <= KR4_FEC_HI) region = RGN_KR4_FEC;
            else if (addr >= KR4_AN_LO && addr <= KR4_AN_HI) region = RGN_KR4_AN;
            else if (addr >= KR4_LT_LO && addr <= KR4_LT_HI) region = RGN_KR4_LT;
         end
      end else if (addr >= WINDOW_LO) begin
         if (!OLDER_FAMILY && !FOUR_LANE) region = RGN_WINDOW;
      end else if (addr <= XCVR_CSR_HI) begin
         region = RGN_XCVR_CSR;
      end else if (addr >= LOCK_LO && addr <= LOCK_HI) begin
         region = RGN_LOCK;
      end else if (addr >= BIT_ERR_LO && addr <= BIT_ERR_HI) begin
         region = RGN_BIT_ERR;
      end else if ((addr >= PCS_HW_ERROR_OFS && addr <= LINK_FAULT_OFS) || addr == PHY_RESET_OFS) begin
         region = RGN_LOCAL;
      end else if (addr >= VLANE_LO && addr <= VLANE_HI) begin
         region = RGN_VLANE;
      end else if (addr >= PATTERN_LO && addr <= PATTERN_HI) begin
         region = RGN_PATTERN;
      end
   end
endmodule : csr_region_decode

// file: hdl/eth_phy_csr_address_decoder.sv
/*
 Control and status address decoder: routes host word accesses to PCS,
 transceiver window, KR4 and MAC areas, holds the single-word PCS registers,
 drops reserved writes and answers reserved reads with a constant.
 Assumes external areas answer a read with ext_rvalid within bounded time and
 that the host issues one access at a time.
*/
`timescale 1ns/100ps
module eth_phy_csr_address_decoder import csr_decode_pkg::*; #(
   parameter bit OLDER_FAMILY = 1'b0,
   parameter bit FOUR_LANE = 1'b0,
   parameter bit HAS_KR4 = 1'b1
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // host side
   input wire host_req_s host_req,
   output host_rsp_s host_rsp,
   // external areas
   output area_req_s area_req,
   input wire logic [DATA_W-1:0] ext_rdata,
   input wire logic ext_rvalid,
   // pcs status inputs and control outputs
   input wire logic [31:0] hw_error_in,
   input wire logic [31:0] ber_status_in,
   input wire logic [31:0] pattern_count_in,
   input wire logic [31:0] fault_status_in,
   output logic [31:0] test_mode_ctrl,
   output logic [31:0] link_fault_ctrl,
   output logic [31:0] phy_reset_ctrl
);
   typedef struct packed {
      host_rsp_s rsp;
      area_req_s area;
      logic ext_pending;
      logic [31:0] test_mode;
      logic [31:0] link_fault;
      logic [31:0] phy_reset;
   } state_s;

   state_s state_reg, state_next;
   region_e region;

   // region lookup for the current word address
   csr_region_decode #(
      .OLDER_FAMILY(OLDER_FAMILY),
      .FOUR_LANE(FOUR_LANE),
      .HAS_KR4(HAS_KR4)
   ) u_decode (
      .addr(host_req.addr),
      .region(region)
   );

   // next state: local registers, routing and read answers
   always_comb begin
      state_next = state_reg;
      state_next.rsp.rvalid = 1'b0;
      state_next.area.read = 1'b0;
      state_next.area.write = 1'b0;
      // complete a forwarded read
      if (state_reg.ext_pending && ext_rvalid) begin
         state_next.ext_pending = 1'b0;
         state_next.rsp.rvalid = 1'b1;
         state_next.rsp.rdata = ext_rdata;
      end
      if (host_req.write) begin
         case (region)
            RGN_LOCAL: begin
               // only writable bits change, read-only bits keep value
               case (host_req.addr)
                  TEST_MODE_OFS: state_next.test_mode =
                     (state_reg.test_mode & ~TEST_MODE_WMASK) | (host_req.wdata & TEST_MODE_WMASK);
                  LINK_FAULT_OFS: state_next.link_fault =
                     (state_reg.link_fault & ~LINK_FAULT_WMASK) | (host_req.wdata & LINK_FAULT_WMASK);
                  PHY_RESET_OFS: state_next.phy_reset =
                     (state_reg.phy_reset & ~PHY_RESET_WMASK) | (host_req.wdata & PHY_RESET_WMASK);
                  default: ; // status-only words ignore writes
               endcase
            end
            RGN_RESERVED: ; // write dropped
            default: begin
               state_next.area.region = region;
               state_next.area.addr = host_req.addr;
               state_next.area.wdata = host_req.wdata;
               state_next.area.write = 1'b1;
            end
         endcase
      end else if (host_req.read) begin
         case (region)
            RGN_LOCAL: begin
               state_next.rsp.rvalid = 1'b1;
               case (host_req.addr)
                  PCS_HW_ERROR_OFS: state_next.rsp.rdata = hw_error_in;
                  BER_MONITOR_OFS: state_next.rsp.rdata = ber_status_in;
                  TEST_MODE_OFS: state_next.rsp.rdata = state_reg.test_mode;
                  TEST_PATTERN_OFS: state_next.rsp.rdata = pattern_count_in;
                  LINK_FAULT_OFS: state_next.rsp.rdata = state_reg.link_fault | (fault_status_in & ~LINK_FAULT_WMASK);
                  PHY_RESET_OFS: state_next.rsp.rdata = state_reg.phy_reset;
                  default: state_next.rsp.rdata = RESERVED_DATA;
               endcase
            end
            RGN_RESERVED: begin
               state_next.rsp.rvalid = 1'b1;
               state_next.rsp.rdata = RESERVED_DATA;
            end
            default: begin
               state_next.area.region = region;
               state_next.area.addr = host_req.addr;
               state_next.area.read = 1'b1;
               state_next.ext_pending = 1'b1;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= '{rsp: '{rdata: 32'h0000_0000, rvalid: 1'b0},
                        area: '{region: RGN_RESERVED, addr: 16'h0000, read: 1'b0, write: 1'b0,
                                wdata: 32'h0000_0000},
                        ext_pending: 1'b0, test_mode: CTRL_RESET, link_fault: CTRL_RESET,
                        phy_reset: CTRL_RESET};
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs straight from flops
   assign host_rsp = state_reg.rsp;
   assign area_req = state_reg.area;
   assign test_mode_ctrl = state_reg.test_mode;
   assign link_fault_ctrl = state_reg.link_fault;
   assign phy_reset_ctrl = state_reg.phy_reset;
endmodule : eth_phy_csr_address_decoder

// file: bench/csr_decode_checker.sv
/* checker: decode, forwarding and answer timing of the address decoder
   assumes the default build: newer family, not four-lane, KR4 present */
`timescale 1ns/100ps
module csr_decode_checker import csr_decode_pkg::*; (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // host and area sides
   input wire host_req_s host_req,
   input wire host_rsp_s host_rsp,
   input wire area_req_s area_req,
   input wire logic [DATA_W-1:0] ext_rdata,
   input wire logic ext_rvalid,
   input wire logic [31:0] test_mode_ctrl
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // request qualifiers, write wins over read
   wire rd_q = host_req.read && !host_req.write;
   wire wr_q = host_req.write;
   wire [15:0] addr_q = host_req.addr;
   a_local_read: assert property (rd_q && addr_q == TEST_MODE_OFS |=>
      host_rsp.rvalid && !area_req.read)
      else $error("local read not answered locally");
   a_rsvd_read_zero: assert property (rd_q && addr_q == 16'h001C |=>
      host_rsp.rvalid && host_rsp.rdata == RESERVED_DATA)
      else $error("reserved read not zero");
   a_rsvd_write_drop: assert property (wr_q && addr_q inside {16'h000A, 16'h001C, 16'h00BE} |=>
      !area_req.write && !host_rsp.rvalid && $stable(test_mode_ctrl))
      else $error("reserved write had an effect");
   a_mode_write_mask: assert property (wr_q && addr_q == TEST_MODE_OFS |=>
      test_mode_ctrl == ($past(host_req.wdata) & TEST_MODE_WMASK))
      else $error("test mode write mask wrong");
   a_window_pass: assert property (rd_q && addr_q inside {[WINDOW_LO:WINDOW_HI]} |=>
      area_req.read && area_req.region == RGN_WINDOW && area_req.addr == $past(addr_q))
      else $error("window read not passed through");
   a_fec_route: assert property (rd_q && addr_q inside {[KR4_FEC_LO:KR4_FEC_HI]} |=>
      area_req.read && area_req.region == RGN_KR4_FEC)
      else $error("fec read misrouted");
   a_lt_route: assert property (rd_q && addr_q inside {[KR4_LT_LO:KR4_LT_HI]} |=>
      area_req.region == RGN_KR4_LT)
      else $error("link training read misrouted");
   a_kr4_gap: assert property (rd_q && addr_q inside {[KR4_LO:16'h00AF], [16'h00CD:16'h00CF]} |=>
      host_rsp.rvalid && !area_req.read)
      else $error("kr4 gap read forwarded");
   a_mac_route: assert property (rd_q && addr_q >= MAC_LO |=> area_req.region == RGN_MAC)
      else $error("mac read misrouted");
   a_ext_answer: assert property (ext_rvalid |=>
      host_rsp.rvalid && host_rsp.rdata == $past(ext_rdata))
      else $error("area answer not returned");
   // main scenarios
   cover property (rd_q ##1 area_req.read);
   cover property (wr_q && addr_q == 16'h001C);
   cover property (ext_rvalid ##1 host_rsp.rvalid);
endmodule : csr_decode_checker
bind eth_phy_csr_address_decoder csr_decode_checker u_csr_decode_checker (.ref_clk, .arst_n, .host_req,
   .host_rsp, .area_req, .ext_rdata, .ext_rvalid, .test_mode_ctrl);

// file: bench/area_model.sv
/* model of the external areas: answers forwarded reads and counts writes
   assumes one outstanding read at a time */
`timescale 1ns/100ps
module area_model import csr_decode_pkg::*; (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // routed access and answer
   input wire area_req_s area_req,
   output logic [DATA_W-1:0] ext_rdata,
   output logic ext_rvalid,
   output logic [7:0] wr_count
);
   logic [2:0] wait_cnt;
   logic [ADDR_W-1:0] rd_addr;
   // answers a whole word four cycles after the read request; idle data shows the inverse
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wait_cnt <= 3'h0;
         rd_addr <= 16'h0000;
         ext_rvalid <= 1'b0;
         ext_rdata <= 32'h0000_0000;
         wr_count <= 8'h00;
      end else begin
         ext_rvalid <= (wait_cnt == 3'h1);
         ext_rdata <= (wait_cnt == 3'h1) ? {16'hA5A5, rd_addr} : ~ext_rdata;
         if (area_req.read) begin
            wait_cnt <= 3'h3;
            rd_addr <= area_req.addr;
         end else if (wait_cnt != 3'h0) begin
            wait_cnt <= wait_cnt - 3'h1;
         end
         if (area_req.write) begin
            wr_count <= wr_count + 8'h01;
         end
      end
   end
endmodule : area_model

// file: bench/eth_phy_csr_address_decoder_test.sv
/* bench: host word accesses into the decoder, an area model answers forwarded ones
   assumes the default build parameters */
`timescale 1ns/100ps
module eth_phy_csr_address_decoder_test import csr_decode_pkg::*;;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   host_req_s host_req = '0;
   host_rsp_s host_rsp;
   area_req_s area_req;
   logic [DATA_W-1:0] ext_rdata;
   logic ext_rvalid;
   logic [7:0] wr_count;
   logic [31:0] test_mode_ctrl, link_fault_ctrl, phy_reset_ctrl, seen;
   logic [31:0] fault_in = 32'hABCD_EF00;
   int fails = 0;
   int checked = 0;
   logic [15:0] rsvd [15] = '{16'h000A, 16'h000F, 16'h001C, 16'h001E, 16'h001F, 16'h0024, 16'h002F,
      16'h0033, 16'h003F, 16'h0080, 16'h00AF, 16'h00BE, 16'h00CD, 16'h00EC, 16'h00FF};
   logic [15:0] fwd [20] = '{16'h0000, 16'h0009, 16'h0010, 16'h0014, 16'h0015, 16'h0016, 16'h0020, 16'h0023,
      16'h0030, 16'h0032, 16'h0040, 16'h007F, 16'h00B0, 16'h00BD, 16'h00C0, 16'h00CC, 16'h00D0, 16'h00EB,
      16'h0100, 16'hFFFF};
   logic [15:0] ro_addr [3] = '{PCS_HW_ERROR_OFS, BER_MONITOR_OFS, TEST_PATTERN_OFS};
   logic [31:0] ro_val [3] = '{32'h1234_5678, 32'h0BAD_F00D, 32'h0000_00C3};
   always #5 ref_clk = ~ref_clk;
   // default build only, absent registers are never relied on
   eth_phy_csr_address_decoder u_eth_phy_csr_address_decoder (.ref_clk(ref_clk), .arst_n(arst_n),
      .host_req(host_req), .host_rsp(host_rsp), .area_req(area_req), .ext_rdata(ext_rdata),
      .ext_rvalid(ext_rvalid), .hw_error_in(ro_val[0]), .ber_status_in(ro_val[1]),
      .pattern_count_in(ro_val[2]), .fault_status_in(fault_in), .test_mode_ctrl(test_mode_ctrl),
      .link_fault_ctrl(link_fault_ctrl), .phy_reset_ctrl(phy_reset_ctrl));
   area_model u_area_model (.ref_clk(ref_clk), .arst_n(arst_n), .area_req(area_req), .ext_rdata(ext_rdata),
      .ext_rvalid(ext_rvalid), .wr_count(wr_count));
   // compare and count
   task check(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : check
   // one-cycle read request, then wait a bounded time for the answer
   task rd(input logic [15:0] a, output logic [31:0] d);
      int n;
      @(negedge ref_clk);
      host_req.addr = a;
      host_req.read = 1'b1;
      @(negedge ref_clk);
      host_req.read = 1'b0;
      for (n = 0; n < 20 && host_rsp.rvalid !== 1'b1; n++) @(negedge ref_clk);
      if (n == 20) fails++;
      d = host_rsp.rdata;
   endtask : rd
   // one-cycle write request
   task wr(input logic [15:0] a, input logic [31:0] d);
      @(negedge ref_clk);
      host_req.addr = a;
      host_req.wdata = d;
      host_req.write = 1'b1;
      @(negedge ref_clk);
      host_req.write = 1'b0;
   endtask : wr
   // verdict and end of run
   task results();
      if (fails == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : results
   // main sequence
   initial begin
      int i;
      logic [7:0] cnt;
      repeat (6) @(negedge ref_clk);
      arst_n = 1'b1;
      rd(PHY_RESET_OFS, seen);
      check(seen, CTRL_RESET);
      wr(TEST_MODE_OFS, 32'hFFFF_FFFF);
      wr(LINK_FAULT_OFS, 32'hFFFF_FFFF);
      wr(PHY_RESET_OFS, 32'hFFFF_FFF5);
      check(test_mode_ctrl, TEST_MODE_WMASK);
      check(link_fault_ctrl, LINK_FAULT_WMASK);
      check(phy_reset_ctrl, 32'h0000_0005);
      rd(TEST_MODE_OFS, seen);
      check(seen, 32'h0000_000F);
      // bits above the writable ones show the fault status input
      rd(LINK_FAULT_OFS, seen);
      check(seen, 32'hABCD_EF07);
      for (i = 0; i < 3; i++) begin
         wr(ro_addr[i], 32'h0000_0000);
         rd(ro_addr[i], seen);
         check(seen, ro_val[i]);
      end
      cnt = wr_count;
      for (i = 0; i < 15; i++) begin
         wr(rsvd[i], 32'h0000_0000);
         rd(rsvd[i], seen);
         check(seen, RESERVED_DATA);
      end
      check(wr_count, cnt);
      check(test_mode_ctrl, 32'h0000_000F);
      // forwarded writes carry the same word address and the whole data word
      for (i = 0; i < 20; i++) begin
         wr(fwd[i], {16'hC3C3, fwd[i]});
         check(area_req.addr, fwd[i]);
         check(area_req.wdata, {16'hC3C3, fwd[i]});
         rd(fwd[i], seen);
         check(seen, {16'hA5A5, fwd[i]});
      end
      check(wr_count, cnt + 8'h14);
      // reset in mid-run returns the control registers to their reset value
      @(negedge ref_clk);
      arst_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      arst_n = 1'b1;
      check(test_mode_ctrl, CTRL_RESET);
      check(link_fault_ctrl, CTRL_RESET);
      check(phy_reset_ctrl, CTRL_RESET);
      rd(TEST_MODE_OFS, seen);
      check(seen, CTRL_RESET);
      results();
   end
   // watchdog
   initial begin
      #200000;
      fails++;
      results();
   end
endmodule : eth_phy_csr_address_decoder_test
